// [src/clkrst_pkg.sv]
// Package with register offsets, field positions, reset values and timing constants.
package clkrst_pkg;

    localparam int          CLK_HZ          = 10_000_000;
    localparam int          SETTLE_US       = 1000;
    localparam int          SETTLE_CYCLES   = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int          RST_MIN_NS      = 100;
    localparam int          RST_MIN_CYCLES  = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          CIC_HOLD_MCLK   = 80;
    localparam int          MCLK_DIV        = 4;
    localparam int          NULL_SYMBOLS    = 20;

    localparam logic [7:0]  ADDR_CTRL0      = 8'h00;
    localparam logic [7:0]  ADDR_REFDIV     = 8'h01;
    localparam logic [7:0]  ADDR_PWR        = 8'h02;
    localparam logic [7:0]  ADDR_ADCCLK     = 8'h08;
    localparam logic [7:0]  ADDR_TXCLK      = 8'h20;

    localparam logic [7:0]  RST_CTRL0       = 8'h08;
    localparam logic [7:0]  RST_REFDIV      = 8'h00;
    localparam logic [7:0]  RST_PWR         = 8'h00;
    localparam logic [7:0]  RST_ADCCLK      = 8'h80;
    localparam logic [7:0]  RST_TXCLK       = 8'h00;

    localparam int          SWRST_BIT       = 5;
    localparam int          LOCK_BIT        = 7;
    localparam int          TXPD_BIT        = 5;
    localparam int          ADC_DIRECT_BIT  = 7;
    localparam int          TXMUX_BIT       = 4;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic osc_en;
        logic sys_en;
        logic mclk_en;
        logic dac_en;
        logic txport_en;
        logic adc_en;
        logic ref_en;
    } clk_en_t;

    function automatic logic [4:0] lsel(input logic [1:0] code);
        unique case (code)
            2'h0: lsel = 5'h01;
            2'h1: lsel = 5'h02;
            2'h2: lsel = 5'h03;
            default: lsel = 5'h08;
        endcase
    endfunction

    function automatic logic [2:0] ksel(input logic [1:0] code);
        unique case (code)
            2'h0: ksel = 3'h1;
            2'h1: ksel = 3'h2;
            default: ksel = 3'h4;
        endcase
    endfunction

endpackage

// [src/clock_reset_tx_powerdown.sv]
// Clock enable generation, reset sequencing and transmit power-down control.
// Summary of operation
// R01: System clock enable runs at oscillator rate times multiplier; all others except the oscillator-rate reference output derive from it.
// R02: Master clock enable is system clock divided by four.
// R03: DAC clock is oscillator times L, L limited to 1, 2, 3 or 8.
// R04: Interpolation factor 1, 2 or 4 divides DAC rate to transmit port rate.
// R05: Multiplexer on: transmit port takes half words at twice DAC over K; with K of 1 the code ticks the port at DAC rate.
// R06: Multiplexer off: transmit port takes data at DAC over K.
// R07: Quadrature converter bus is clocked by master clock, four times sample rate.
// R08: Intermediate-frequency converter words leave at one per master clock.
// R09: Register 0x08 selects converter clock direct from oscillator or multiplied; the code stores the register but no output uses it.
// R10: Reference output is master over R for R 2 or 3, else oscillator.
// R11: Loop settles within one millisecond after reset or multiplier change.
// R12: Host keeps power-down low in reset and settling, programs clocks first.
// R13: Host pulses power-down after settling if it could not hold it low.
// R14: Host holds reset low for at least 100 ns.
// R15: Reset low stops clocks; release restarts multiplier and reloads defaults.
// R16: Writing bit 5 of register 0x00 resets all but register 0x00.
// R17: Power-down low stops transmit clocks and resets the comb filter.
// R18: Comb filter stays in reset 80 master cycles after power-down rises.
// R19: Host pads burst end with 20 null symbols before power-down; the host model counts only the first 20 port ticks after release.
// R20: Host starts each burst with 20 null symbols after power-down release.
// R21: Software power-down bit 5 acts like the pin once written.
// R22: Host sends transmit data only after lock and power-down high.
// R23: Multiplier factor sits in bits 4 to 0 of register 0x00.
// R24: Settling interval is counted and lock is flagged only when it completes.
`timescale 1ns/1ps
module clock_reset_tx_powerdown
    import clkrst_pkg::*;
#(
    parameter int SETTLE_CNT = SETTLE_CYCLES,
    parameter int CIC_HOLD   = CIC_HOLD_MCLK
) (
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       RESET_N,
    input  wire logic       TX_POWERDOWN_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output      logic [7:0] RDATA,
    output      logic       SYS_EN,
    output      logic       MCLK_EN,
    output      logic       DAC_EN,
    output      logic       TXPORT_EN,
    output      logic       IQ_BUS_EN,
    output      logic       IF_WORD_EN,
    output      logic       REF_EN,
    output      logic       CIC_RESET,
    output      logic       LOCKED
);
    // The oscillator itself is modelled by CLK: each CLK edge is one oscillator period.
    // Multiplied rates are expressed as counts of sub-ticks per oscillator period.
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] refdiv;
        logic [7:0] pwr;
        logic [7:0] adcclk;
        logic [7:0] txclk;
        logic [7:0] rdata;
        logic       rst_n_prev;
        logic [7:0] cic_cnt;
        logic       cic_rst;
        logic [4:0] sys_acc;
        logic [4:0] dac_acc;
        logic [1:0] mclk_ph;
        logic       o_sys;
        logic       o_mclk;
        logic       o_dac;
        logic       o_txport;
        logic       o_iq;
        logic       o_ifw;
        logic       o_ref;
        logic       o_cic;
        logic       o_lock;
    } st_t;
    st_t s_q, s_d;

    bus_req_t   req;
    logic       in_reset;
    logic       sw_reset;
    logic       mult_chg;
    logic       restart;
    logic       locked;
    logic       tx_run;
    logic       txp_pulse;
    logic       ref_pulse;
    logic [2:0] k_div;
    logic [2:0] tx_div;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign in_reset = ~RESET_N;                                                          // R15
    assign sw_reset = req.wr && req.addr == ADDR_CTRL0 && req.wdata[SWRST_BIT];          // R16
    assign mult_chg = req.wr && req.addr == ADDR_CTRL0 && req.wdata[4:0] != s_q.ctrl0[4:0];
    assign restart  = in_reset || sw_reset || mult_chg || (RESET_N && !s_q.rst_n_prev); // R11 R24
    // A software write to bit 5 of register 0x02 takes effect in the cycle after the write.
    assign tx_run   = TX_POWERDOWN_N && !s_q.pwr[TXPD_BIT] && !in_reset;                 // R17 R21
    assign k_div    = ksel(s_q.txclk[3:2]);                                              // R04
    // With the multiplexer on the port ticks twice per K DAC cycles, so K/2 unless K is 1.
    assign tx_div   = s_q.txclk[TXMUX_BIT] ? ((k_div == 3'h1) ? 3'h1 : (k_div >> 1)) : k_div; // R05 R06

    settle_timer #(
        .CYCLES (SETTLE_CNT)
    ) u_settle (
        .clk     (CLK),
        .rst     (SRST),
        .restart (restart),                                                              // R11 R24
        .locked  (locked)
    );

    rate_div #(
        .W (3)
    ) u_txp (
        .clk    (CLK),
        .rst    (SRST || !tx_run),
        .en_in  (s_d.o_dac),
        .div    (tx_div),
        .en_out (txp_pulse)
    );

    rate_div #(
        .W (6)
    ) u_ref (
        .clk    (CLK),
        .rst    (SRST || in_reset),
        .en_in  (s_d.o_mclk),
        .div    (s_q.refdiv[5:0]),
        .en_out (ref_pulse)
    );

    always_comb begin
        s_d = s_q;
        s_d.rst_n_prev = RESET_N;
        s_d.rdata = 8'h00;
        if (req.wr) begin
            unique case (req.addr)
                ADDR_CTRL0:  s_d.ctrl0 = {req.wdata[7:6], 1'b0, req.wdata[4:0]};         // R23
                ADDR_REFDIV: s_d.refdiv = {2'h0, req.wdata[5:0]};
                ADDR_PWR:    s_d.pwr = req.wdata;                                         // R21
                ADDR_ADCCLK: s_d.adcclk = req.wdata;                                      // R09
                ADDR_TXCLK:  s_d.txclk = {3'h0, req.wdata[4:0]};
                default: ;
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                ADDR_CTRL0:  s_d.rdata = s_q.ctrl0;
                ADDR_REFDIV: s_d.rdata = {locked, s_q.refdiv[6:0]};
                ADDR_PWR:    s_d.rdata = s_q.pwr;
                ADDR_ADCCLK: s_d.rdata = s_q.adcclk;
                ADDR_TXCLK:  s_d.rdata = s_q.txclk;
                default:     s_d.rdata = 8'h00;
            endcase
        end
        if (in_reset || sw_reset) begin                                                  // R15 R16
            if (in_reset) begin
                s_d.ctrl0 = RST_CTRL0;
            end
            s_d.refdiv = RST_REFDIV;
            s_d.pwr = RST_PWR;
            s_d.adcclk = RST_ADCCLK;
            s_d.txclk = RST_TXCLK;
        end
        // Sub-tick accumulators: an enable is high on any CLK cycle carrying a sub-tick.
        s_d.sys_acc = in_reset ? 5'h00 : s_q.ctrl0[4:0];                                // R01
        s_d.dac_acc = in_reset ? 5'h00 : lsel(s_q.txclk[1:0]);                          // R03
        s_d.o_sys = s_d.sys_acc != 5'h00;
        s_d.o_dac = s_d.o_sys && s_d.dac_acc != 5'h00 && tx_run;                        // R17
        if (in_reset) begin
            s_d.mclk_ph = 2'h0;
            s_d.o_mclk = 1'b0;
        end else begin
            s_d.mclk_ph = s_q.mclk_ph + 2'h1;
            s_d.o_mclk = s_d.o_sys && s_q.mclk_ph == 2'(MCLK_DIV - 1);                  // R01 R02
        end
        s_d.o_iq = s_d.o_mclk;                                                           // R07
        s_d.o_ifw = s_d.o_mclk;                                                          // R08
        s_d.o_ref = (s_q.refdiv[5:0] == 6'h02 || s_q.refdiv[5:0] == 6'h03) ? ref_pulse : !in_reset; // R10
        s_d.o_txport = txp_pulse && tx_run;
        if (!tx_run) begin                                                               // R17
            s_d.cic_rst = 1'b1;
            s_d.cic_cnt = 8'h00;
        end else if (s_q.cic_rst && s_q.o_mclk) begin                                    // R18
            if (s_q.cic_cnt == 8'(CIC_HOLD - 1)) begin
                s_d.cic_rst = 1'b0;
            end else begin
                s_d.cic_cnt = s_q.cic_cnt + 8'h01;
            end
        end
        s_d.o_cic = s_d.cic_rst;
        // The timer clears lock a cycle after a restart, so the flag is masked in that cycle.
        s_d.o_lock = locked && !restart;                                                 // R15 R24
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            s_q <= '{ctrl0: RST_CTRL0, refdiv: RST_REFDIV, pwr: RST_PWR, adcclk: RST_ADCCLK,
                     txclk: RST_TXCLK, cic_rst: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA      = s_q.rdata;
    assign SYS_EN     = s_q.o_sys;
    assign MCLK_EN    = s_q.o_mclk;
    assign DAC_EN     = s_q.o_dac;
    assign TXPORT_EN  = s_q.o_txport;
    assign IQ_BUS_EN  = s_q.o_iq;
    assign IF_WORD_EN = s_q.o_ifw;
    assign REF_EN     = s_q.o_ref;
    assign CIC_RESET  = s_q.o_cic;
    assign LOCKED     = s_q.o_lock;
endmodule // clock_reset_tx_powerdown

// [src/rate_div.sv]
// Enable divider: emits one pulse per DIV input enables.
`timescale 1ns/1ps
module rate_div
    import clkrst_pkg::*;
#(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         en_in,
    input  wire logic [W-1:0] div,
    output      logic         en_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
    } st_t;
    st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.pulse = 1'b0;
        if (en_in) begin
            if (s_q.cnt >= div - W'(1)) begin
                s_d.cnt = '0;
                s_d.pulse = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // The pulse is registered, so it trails the counted enable by one cycle; the rate is unchanged.
    assign en_out = s_q.pulse;
endmodule // rate_div

// [src/settle_timer.sv]
// Settling counter that flags lock once a restartable interval has elapsed.
`timescale 1ns/1ps
module settle_timer #(
    parameter int CYCLES = 10000
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic restart,
    output      logic locked
);
    typedef struct packed {
        logic [$clog2(CYCLES+1)-1:0] cnt;
        logic                        lock;
    } st_t;
    st_t s_q, s_d;
    localparam logic [$clog2(CYCLES+1)-1:0] LAST = ($clog2(CYCLES+1))'(CYCLES - 1);

    always_comb begin
        s_d = s_q;
        if (restart) begin
            s_d.cnt = '0;
            s_d.lock = 1'b0;
        end else if (!s_q.lock) begin
            if (s_q.cnt == LAST) begin
                s_d.lock = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign locked = s_q.lock;
endmodule // settle_timer

// [tb/clkrst_sva.sv]
// Port-level assertions for the clock, reset and transmit power-down block.
`timescale 1ns/1ps
module clkrst_sva
    import clkrst_pkg::*;
#(
    parameter int SETTLE_CNT = 20,
    parameter int CIC_HOLD   = 80
) (
    input wire logic       CLK,
    input wire logic       SRST,
    input wire logic       RESET_N,
    input wire logic       TX_POWERDOWN_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       SYS_EN,
    input wire logic       MCLK_EN,
    input wire logic       TXPORT_EN,
    input wire logic       IQ_BUS_EN,
    input wire logic       IF_WORD_EN,
    input wire logic       CIC_RESET,
    input wire logic       LOCKED
);
    localparam int LK_HI = SETTLE_CNT + 4;
    int hold_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST || !RESET_N);
    // Any write that may move the software power-down restarts the count, so it never spans two holds.
    always_ff @(posedge CLK) begin
        if (SRST || !RESET_N || !TX_POWERDOWN_N || !CIC_RESET || (WR && (ADDR == ADDR_PWR || ADDR == ADDR_CTRL0)))
            hold_q <= 0;
        else if (MCLK_EN)
            hold_q <= hold_q + 1;
    end
    property p_sys_base; MCLK_EN |-> SYS_EN; endproperty
    a_sys_base: assert property (p_sys_base) else $error("master enable without system enable");
    property p_mclk_gap; MCLK_EN |=> !MCLK_EN [*3]; endproperty
    a_mclk_gap: assert property (p_mclk_gap) else $error("master enable faster than one in four");
    property p_iq_gap; IQ_BUS_EN |=> !IQ_BUS_EN [*3]; endproperty
    a_iq_gap: assert property (p_iq_gap) else $error("quadrature bus faster than master clock");
    property p_if_gap; IF_WORD_EN |=> !IF_WORD_EN [*3]; endproperty
    a_if_gap: assert property (p_if_gap) else $error("converter words faster than master clock");
    property p_pd_stop; !TX_POWERDOWN_N |=> CIC_RESET && !TXPORT_EN; endproperty
    a_pd_stop: assert property (p_pd_stop) else $error("transmit path runs in power-down");
    property p_cic_hold; $fell(CIC_RESET) |-> hold_q >= CIC_HOLD - 1 && hold_q <= CIC_HOLD + 1; endproperty
    a_cic_hold: assert property (p_cic_hold) else $error("comb reset hold length wrong");
    property p_rst_stop; disable iff (SRST) !RESET_N |=> !SYS_EN && !MCLK_EN && !LOCKED; endproperty
    a_rst_stop: assert property (p_rst_stop) else $error("clocks run during reset");
    property p_lock_wait; $rose(RESET_N) |=> (!LOCKED) [*8] ##[1:LK_HI] LOCKED; endproperty
    a_lock_wait: assert property (p_lock_wait) else $error("lock early or late after reset");
    property p_swpd; WR && ADDR == ADDR_PWR && WDATA[TXPD_BIT] |-> ##[1:2] CIC_RESET; endproperty
    a_swpd: assert property (p_swpd) else $error("software power-down ignored");
endmodule // clkrst_sva
bind clock_reset_tx_powerdown clkrst_sva #(.SETTLE_CNT(SETTLE_CNT), .CIC_HOLD(CIC_HOLD)) u_sva (.CLK(CLK),
    .SRST(SRST), .RESET_N(RESET_N), .TX_POWERDOWN_N(TX_POWERDOWN_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .SYS_EN(SYS_EN), .MCLK_EN(MCLK_EN), .TXPORT_EN(TXPORT_EN), .IQ_BUS_EN(IQ_BUS_EN), .IF_WORD_EN(IF_WORD_EN),
    .CIC_RESET(CIC_RESET), .LOCKED(LOCKED));

// [tb/host_ctrl_model.sv]
// Host model that sequences the reset and power-down pins.
`timescale 1ns/1ps
module host_ctrl_model
    import clkrst_pkg::*;
#(
    parameter int RST_LOW = 3
) (
    input  wire logic clk,
    input  wire logic rst_req,
    input  wire logic pd_req,
    input  wire logic locked,
    input  wire logic txport_en,
    output      logic reset_n,
    output      logic pd_n
);
    int low_q = 0;
    int null_q = 0;
    initial begin
        reset_n = 1'b0;
        pd_n = 1'b0;
    end
    always @(posedge clk) begin
        if (rst_req)
            low_q <= RST_LOW;
        else if (low_q > 0)
            low_q <= low_q - 1;
        reset_n <= !(rst_req || low_q > 1);
        // The host only sends null symbols, so each of the first NULL_SYMBOLS port ticks since release counts as padding.
        if (!pd_n)
            null_q <= 0;
        else if (txport_en && null_q < NULL_SYMBOLS)
            null_q <= null_q + 1;
        // Power-down only lifts once the loop reports lock, so the filter always starts clean.
        // A requested power-down waits only until NULL_SYMBOLS port ticks have gone out since the release.
        pd_n <= reset_n && locked && (pd_req || (pd_n && null_q < NULL_SYMBOLS));
    end
endmodule // host_ctrl_model

// [tb/tb_clock_reset_tx_powerdown.sv]
// Self-checking bench for the clock, reset and transmit power-down block.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_clock_reset_tx_powerdown;
    import clkrst_pkg::*;
    localparam int CH = 16;
    localparam int E_MCLK = 0, E_REF = 1, E_TXP = 2, E_DAC = 3;
    logic       CLK = 1'b0, SRST = 1'b1, WR = 1'b0, RD = 1'b0, rst_req = 1'b1, pd_req = 1'b0;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, got, r;
    logic       RESET_N, TX_POWERDOWN_N, SYS_EN, MCLK_EN, DAC_EN, TXPORT_EN, IQ_BUS_EN, IF_WORD_EN, REF_EN;
    logic       CIC_RESET, LOCKED;
    logic [3:0] ens;
    logic [31:0] seed = 32'hC226;
    logic [4:0] m = 5'h08;
    int         failures = 0, check_count = 0, cyc = 0, n;
    logic [7:0] ra [6] = '{ADDR_CTRL0, ADDR_REFDIV, ADDR_PWR, ADDR_ADCCLK, ADDR_TXCLK, 8'h05};
    logic [7:0] rv [6] = '{RST_CTRL0, RST_REFDIV | 8'h80, RST_PWR, RST_ADCCLK, RST_TXCLK, 8'h00};
    always #50 CLK = ~CLK;
    assign ens = {DAC_EN, TXPORT_EN, REF_EN, MCLK_EN};
    host_ctrl_model u_host (.clk(CLK), .rst_req(rst_req), .pd_req(pd_req), .locked(LOCKED), .reset_n(RESET_N),
        .txport_en(TXPORT_EN), .pd_n(TX_POWERDOWN_N));
    clock_reset_tx_powerdown #(.SETTLE_CNT(20), .CIC_HOLD(CH)) u_dut (.CLK(CLK), .SRST(SRST), .RESET_N(RESET_N),
        .TX_POWERDOWN_N(TX_POWERDOWN_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .SYS_EN(SYS_EN), .MCLK_EN(MCLK_EN), .DAC_EN(DAC_EN), .TXPORT_EN(TXPORT_EN), .IQ_BUS_EN(IQ_BUS_EN),
        .IF_WORD_EN(IF_WORD_EN), .REF_EN(REF_EN), .CIC_RESET(CIC_RESET), .LOCKED(LOCKED));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        got = RDATA;
    endtask
    task automatic count_en(input int sel, input int len);
        n = 0;
        repeat (len) begin
            @(posedge CLK);
            if (ens[sel] === 1'b1) n++;
        end
    endtask
    task automatic wait_lock;
        n = 0;
        while (LOCKED !== 1'b1 && n < 200) begin
            @(posedge CLK);
            n++;
        end
        `CHK(LOCKED, 1'b1)
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // The ceiling sits far above the less than a thousand cycles the sequence needs.
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        rst_req <= 1'b0;
        wait_lock();
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            `CHK(got, rv[i])
        end
        count_en(E_MCLK, 40);
        `CHK(n, 10)
        count_en(E_REF, 8);
        `CHK(n, 8)
        $display("test defaults done");
        repeat (3) begin
            seed = lfsr(seed);
            m = {seed[4:2], ~m[1:0]};
            if (m == 5'h00) m = 5'h10;
            wr(ADDR_CTRL0, {3'h0, m});
            rd(ADDR_REFDIV);
            `CHK(got[LOCK_BIT], 1'b0)
            rd(ADDR_CTRL0);
            `CHK(got, {3'h0, m})
            wait_lock();
        end
        r = 8'h02 + {7'h00, seed[7]};
        wr(ADDR_REFDIV, r);
        rd(ADDR_REFDIV);
        `CHK(got, r | 8'h80)
        count_en(E_REF, 48);
        `CHK(n, 12 / int'(r))
        for (int i = 0; i < 12; i++) begin
            wr(ADDR_TXCLK, 8'(i) | (i[0] ? 8'h10 : 8'h00));
            rd(ADDR_TXCLK);
            `CHK(got, 8'(i) | (i[0] ? 8'h10 : 8'h00))
        end
        wr(ADDR_ADCCLK, 8'h00);
        rd(ADDR_ADCCLK);
        `CHK(got, 8'h00)
        $display("test multiplier done");
        wr(ADDR_CTRL0, 8'h20 | {3'h0, m});
        rd(ADDR_CTRL0);
        `CHK(got, {3'h0, m})
        rd(ADDR_REFDIV);
        `CHK(got, RST_REFDIV)
        rd(ADDR_ADCCLK);
        `CHK(got, RST_ADCCLK)
        wait_lock();
        $display("test soft reset done");
        pd_req <= 1'b1;
        repeat (4 * CH - 8) @(posedge CLK);
        `CHK(CIC_RESET, 1'b1)
        repeat (16) @(posedge CLK);
        `CHK(CIC_RESET, 1'b0)
        wr(ADDR_TXCLK, 8'h0B);
        repeat (8) @(posedge CLK);
        count_en(E_DAC, 16);
        `CHK(n, 16)
        count_en(E_TXP, 16);
        `CHK(n, 16 / 4)
        wr(ADDR_TXCLK, 8'h1B);
        repeat (8) @(posedge CLK);
        count_en(E_TXP, 16);
        `CHK(n, 2 * 16 / 4)
        pd_req <= 1'b0;
        repeat (3) @(posedge CLK);
        `CHK(CIC_RESET, 1'b1)
        count_en(E_TXP, 16);
        `CHK(n, 0)
        pd_req <= 1'b1;
        repeat (4 * CH + 16) @(posedge CLK);
        wr(ADDR_PWR, 8'h20);
        repeat (2) @(posedge CLK);
        `CHK(CIC_RESET, 1'b1)
        wr(ADDR_PWR, 8'h00);
        repeat (4 * CH + 16) @(posedge CLK);
        `CHK(CIC_RESET, 1'b0)
        $display("test power-down done");
        rst_req <= 1'b1;
        repeat (3) @(posedge CLK);
        rst_req <= 1'b0;
        wait_lock();
        rd(ADDR_CTRL0);
        `CHK(got, RST_CTRL0)
        $display("test hardware reset done");
        wrap_up();
    end
endmodule // tb_clock_reset_tx_powerdown
